//--- bench/fbcmc_flash_model.sv
module fbcmc_flash_model #(
  parameter logic [15:0] AUTO_ID = 16'h0123,
  parameter logic [15:0] BOOT_FLAG = 16'h0002
) (
  input wire fbcmc_pkg::fbcmc_pins_s pins_i,
  output logic [15:0] dq_o,
  output logic viol_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // AUTO_ID is an arbitrary value; each bank keeps its own mode.
  logic [1:0] mode [4];
  logic [1:0] seq;
  logic sec;
  logic [20:0] lat;
  logic [15:0] last;
  logic [15:0] d;
  logic open_wr = 1'h0;
  wire wr_n = pins_i.ce_n | pins_i.we_n | ~pins_i.oe_n;
  wire rd = ~pins_i.ce_n & ~pins_i.oe_n;

  // Power-up leaves every bank reading array data.
  initial begin
    mode = '{default: 2'h0};
    seq = 2'h0;
    sec = 1'h0;
    viol_o = 1'h0;
    last = 16'h0000;
  end

  // Query words that are not modelled read zero.
  function automatic logic [15:0] rd_word(input logic [20:0] a);
    if (sec) return a[15:0] ^ 16'hC3E1;
    if (mode[a[20:19]] == 2'h1) return AUTO_ID;
    if (mode[a[20:19]] == 2'h0) return a[15:0] ^ 16'h5A3C;
    case (a[7:0])
      8'h4D: return 16'h0085;
      8'h4E: return 16'h0095;
      8'h4F: return BOOT_FLAG;
      8'h50: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction

  // A released bus shows the inverse of its last value, so a late sample cannot pass.
  always @* begin
    if (rd) begin
      dq_o = rd_word(pins_i.addr);
      last = dq_o;
    end else begin
      dq_o = ~last;
    end
  end

  // The address is taken when the write opens; the unknown level before reset opens no write.
  always @(negedge wr_n) begin
    lat = pins_i.addr;
    open_wr = (wr_n === 1'h0);
  end

  // Commands take effect on the edge that closes the write.
  always @(posedge wr_n) begin
    d = pins_i.dq;
    if (open_wr && (pins_i.addr !== lat || pins_i.dq_oe !== 1'h1)) viol_o = 1'h1;
    open_wr = 1'h0;
    if (d == 16'h00F0) begin
      mode = '{default: 2'h0};
      seq = 2'h0;
    end else if (d == 16'h0098 && lat == 21'h000055) begin
      mode = '{default: 2'h2};
    end else if (seq == 2'h0 && d == 16'h00AA && lat == 21'h000555) begin
      seq = 2'h1;
    end else if (seq == 2'h1 && d == 16'h0055 && lat == 21'h0002AA) begin
      seq = 2'h2;
    end else if (seq == 2'h2 && d == 16'h0088) begin
      sec = 1'h1;
      seq = 2'h0;
    end else if (seq == 2'h2 && d == 16'h0090 && sec) begin
      seq = 2'h3;
    end else if (seq == 2'h2 && d == 16'h0090) begin
      mode[lat[20:19]] = 2'h1;
      seq = 2'h0;
    end else begin
      if (seq == 2'h3 && d == 16'h0000) sec = 1'h0;
      seq = 2'h0;
    end
  end
endmodule

//--- bench/fbcmc_host_tb.sv
module fbcmc_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
  } fbcmc_note_s;
  localparam logic [15:0] ID = 16'h0123;  // Arbitrary value.
  logic core_clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic [3:0] sw_addr_i = 4'h0;
  logic [31:0] sw_wdata_i = 32'h0;
  logic sw_wr_i = 1'h0;
  logic sw_rd_i = 1'h0;
  logic [31:0] sw_rdata_o;
  logic [31:0] seen;
  logic [15:0] flash_dq;
  logic viol;
  logic rd_pend = 1'h0;
  logic [7:0] rnd = 8'h0C;
  logic [20:0] ra;
  fbcmc_pkg::fbcmc_pins_s pins;
  fbcmc_note_s notes[$];
  fbcmc_note_s cur;
  int num_errors = 0;
  int check_count = 0;
  int n;

  fbcmc_host u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .flash_dq_i(flash_dq), .flash_o(pins));
  fbcmc_flash_model #(.AUTO_ID(ID)) u_flash (.pins_i(pins), .dq_o(flash_dq), .viol_o(viol));

  // Free-running bench clock.
  always #25 core_clk_i = ~core_clk_i;

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  // Read data stand only in the cycle after the strobe, so the note is taken then.
  always @(posedge core_clk_i) begin
    rd_pend <= sw_rd_i;
    if (rd_pend) begin
      cur = notes.pop_front();
      seen = sw_rdata_o;
      if (cur.mask !== 32'h0) check(sw_rdata_o & cur.mask, cur.exp);
    end
  end

  // One bus cycle; a read notes its expected value, a zero mask marks a poll.
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    sw_wr_i <= w;
    sw_rd_i <= r;
    sw_addr_i <= a;
    sw_wdata_i <= d;
    if (r) notes.push_back('{d & m, m});
    @(posedge core_clk_i);
  endtask

  task automatic op(input fbcmc_pkg::fbcmc_op_e c, input logic [20:0] a, input logic p = 1'h0);
    bus(1'h1, 1'h0, fbcmc_pkg::REG_ADDR, {11'h0, a}, 32'h0);
    bus(1'h1, 1'h0, fbcmc_pkg::REG_CTRL, {28'h0, p, c}, 32'h0);
    for (n = 0; n < 40; n++) begin
      bus(1'h0, 1'h1, fbcmc_pkg::REG_STATUS, 32'h0, 32'h0);
      bus(1'h0, 1'h0, 4'h0, 32'h0, 32'h0);
      #1;
      if (seen[0] === 1'h0) break;
    end
    if (n == 40) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic st(input logic [31:0] e);
    bus(1'h0, 1'h1, fbcmc_pkg::REG_STATUS, e, 32'h0000_FF0F);
  endtask

  task automatic rd(input logic [20:0] a, input logic [15:0] e);
    op(fbcmc_pkg::OP_READ, a);
    bus(1'h0, 1'h1, fbcmc_pkg::REG_RDATA, {16'h0, e}, 32'h0000_FFFF);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence: reset, then each mode entered, read back and left.
  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'h0;
    st(32'h0);
    bus(1'h0, 1'h1, 4'hF, 32'h0, 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      ra = {rnd[1:0], 11'h000, rnd};
      rd(ra, ra[15:0] ^ 16'h5A3C);
    end
    $display("test power-up done");
    op(fbcmc_pkg::OP_AUTOSEL, 21'h100000);
    st(32'h0000_1000);
    rd(21'h100004, ID);
    rd(21'h100008, ID);
    rd(21'h080010, 16'h0010 ^ 16'h5A3C);
    op(fbcmc_pkg::OP_AUTOSEL, 21'h100000);
    st(32'h0000_1004);
    rnd = lfsr(rnd);
    op(fbcmc_pkg::OP_RESET, {rnd[1:0], 11'h000, rnd});
    st(32'h0);
    rd(21'h100004, 16'h0004 ^ 16'h5A3C);
    $display("test autoselect done");
    op(fbcmc_pkg::OP_QUERY, 21'h0);
    st(32'h0000_AA00);
    rd(21'h00004B, 16'h0000);
    rd(21'h00004C, 16'h0000);
    rd(21'h00004E, 16'h0095);
    rd(21'h00004F, 16'h0002);
    op(fbcmc_pkg::OP_RESET, 21'h0);
    $display("test query done");
    op(fbcmc_pkg::OP_SEC_ENTER, 21'h0);
    st(32'h0000_0008);
    rd(21'h000003, 16'h0003 ^ 16'hC3E1);
    op(fbcmc_pkg::OP_SEC_ENTER, 21'h0);
    st(32'h0000_000C);
    op(fbcmc_pkg::OP_SEC_EXIT, 21'h0);
    st(32'h0);
    rd(21'h000003, 16'h0003 ^ 16'h5A3C);
    $display("test secured region done");
    op(fbcmc_pkg::OP_AUTOSEL, 21'h000000);
    st(32'h0000_0100);
    op(fbcmc_pkg::OP_READ, 21'h080000, 1'h1);
    st(32'h0000_0002);
    bus(1'h0, 1'h1, fbcmc_pkg::REG_ADDR, 32'h0008_0000, 32'hFFFF_FFFF);
    bus(1'h1, 1'h0, fbcmc_pkg::REG_STATUS, 32'h0000_0002, 32'h0);
    st(32'h0);
    rd(21'h000004, 16'h0004 ^ 16'h5A3C);
    bus(1'h0, 1'h0, 4'h0, 32'h0, 32'h0);
    repeat (2) @(posedge core_clk_i);
    check({31'h0, viol}, 32'h0);
    $display("test timeout poll done");
    conclude();
  end
endmodule

//--- verilog/fbcmc_host.sv
// Functional notes
// - Autoselect only from read mode, never while another bank is busy.
// - Autoselect is two unlock writes then the bank address with the command.
// - Protection queries present both bank and sector address fields.
// - Three writes enter the secured region; four writes leave it.
// - Query mode is command 98h at address 55h in word mode.
// - A write cycle has select and write strobe low with output strobe high.
module fbcmc_host (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o,
  input wire logic [15:0] flash_dq_i,
  output fbcmc_pkg::fbcmc_pins_s flash_o
);

  // ****************************************************************
  // State.
  // ****************************************************************
  localparam int RESET_LAT = 8;

  fbcmc_pkg::fbcmc_state_e state;
  fbcmc_pkg::fbcmc_state_e next_state;
  fbcmc_pkg::fbcmc_op_e op_q;
  fbcmc_pkg::fbcmc_op_e launch_op;
  fbcmc_pkg::fbcmc_step_s cur;
  fbcmc_pkg::fbcmc_step_s rom_step;
  fbcmc_pkg::fbcmc_step_s pin_step;
  fbcmc_pkg::fbcmc_pins_s next_pins;
  logic [1:0] step;
  logic [1:0] next_step;
  logic [20:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic poll_q;
  logic [7:0] modes;
  logic secured;
  logic timeout_flag;
  logic pending_reset;
  logic refused;
  logic busy;
  logic ctrl_wr;
  logic ctrl_refuse;
  logic ctrl_go;
  logic launch;
  logic tmr_done;
  logic sample;
  logic finish;
  logic timeout_hit;
  logic clr_timeout;
  logic in_cycle;
  logic [1:0] bank_sel;
  logic [1:0] sel_mode;
  fbcmc_pkg::fbcmc_op_e ctrl_op;
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  // ****************************************************************
  // Decode of software requests.
  // ****************************************************************

  // A pending automatic reset counts as busy, so no new order can slip in before it.
  assign busy = (state != fbcmc_pkg::ST_IDLE) || pending_reset;
  assign ctrl_wr = sw_wr_i && (sw_addr_i == fbcmc_pkg::REG_CTRL);
  assign ctrl_op = fbcmc_pkg::fbcmc_op_e'(sw_wdata_i[fbcmc_pkg::CTRL_OP_LSB +: 3]);
  assign bank_sel = addr_q[fbcmc_pkg::BANK_LSB +: 2];
  assign sel_mode = modes[2*bank_sel +: 2];
  assign ctrl_refuse = busy || (ctrl_op > fbcmc_pkg::OP_QUERY)
    || ((ctrl_op == fbcmc_pkg::OP_AUTOSEL) && (sel_mode != fbcmc_pkg::BM_READ))
    || ((ctrl_op == fbcmc_pkg::OP_SEC_ENTER) && secured)
    || ((ctrl_op == fbcmc_pkg::OP_SEC_EXIT) && !secured)
    || ((ctrl_op == fbcmc_pkg::OP_QUERY) && (sel_mode == fbcmc_pkg::BM_QUERY));
  assign ctrl_go = ctrl_wr && !ctrl_refuse;
  assign launch = (state == fbcmc_pkg::ST_IDLE) && (pending_reset || ctrl_go);
  // The automatic reset outranks a software order, though orders are refused while it is pending.
  assign launch_op = pending_reset ? fbcmc_pkg::OP_RESET : ctrl_op;
  assign clr_timeout = sw_wr_i && (sw_addr_i == fbcmc_pkg::REG_STATUS)
    && sw_wdata_i[fbcmc_pkg::ST_TIMEOUT_BIT];

  // ****************************************************************
  // Bus cycle sequencer.
  // ****************************************************************

  // The step index feeds the table one cycle ahead so the pins leave flip-flops.
  assign next_step = (state == fbcmc_pkg::ST_IDLE) ? 2'h0 :
                     (state == fbcmc_pkg::ST_GAP) ? step + 2'h1 : step;

  fbcmc_seq_rom u_rom (
    .op_i(launch ? launch_op : op_q),
    .step_i(next_step),
    .user_addr_i(addr_q),
    .user_data_i(wdata_q),
    .step_o(rom_step)
  );

  fbcmc_pulse_timer #(.W(4)) u_timer (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .load_i(state == fbcmc_pkg::ST_SETUP),
    .load_val_i(cur.rd ? fbcmc_pkg::ACC_CYC : fbcmc_pkg::WP_CYC),
    .done_o(tmr_done)
  );

  // Each cycle walks setup, strobe, hold and gap, so the select rises one cycle after the write
  // strobe and the flash latches data on the strobe's rising edge.
  always_comb begin
    next_state = state;
    case (state)
      fbcmc_pkg::ST_IDLE: if (launch) begin
        next_state = fbcmc_pkg::ST_SETUP;
      end
      fbcmc_pkg::ST_SETUP: next_state = fbcmc_pkg::ST_STROBE;
      fbcmc_pkg::ST_STROBE: if (tmr_done) begin
        next_state = fbcmc_pkg::ST_HOLD;
      end
      fbcmc_pkg::ST_HOLD: next_state = fbcmc_pkg::ST_GAP;
      fbcmc_pkg::ST_GAP: next_state = cur.last ? fbcmc_pkg::ST_IDLE : fbcmc_pkg::ST_SETUP;
      default: next_state = fbcmc_pkg::ST_IDLE;
    endcase
  end

  // Pin levels follow the next state; output strobe stays high on every write cycle.
  assign pin_step = (next_state == fbcmc_pkg::ST_SETUP) ? rom_step : cur;
  assign in_cycle = (next_state == fbcmc_pkg::ST_SETUP) || (next_state == fbcmc_pkg::ST_STROBE)
    || (next_state == fbcmc_pkg::ST_HOLD);
  assign next_pins.ce_n = !in_cycle;
  assign next_pins.we_n = !((next_state == fbcmc_pkg::ST_STROBE) && !pin_step.rd);
  assign next_pins.oe_n = !(in_cycle && pin_step.rd);
  assign next_pins.dq_oe = in_cycle && !pin_step.rd;
  assign next_pins.addr = pin_step.addr;
  assign next_pins.dq = pin_step.data;

  assign sample = (state == fbcmc_pkg::ST_STROBE) && tmr_done && cur.rd;
  assign timeout_hit = sample && poll_q && flash_dq_i[fbcmc_pkg::TIMEOUT_BIT];
  assign finish = (state == fbcmc_pkg::ST_GAP) && cur.last;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= fbcmc_pkg::ST_IDLE;
      step <= 2'h0;
      cur <= '0;
      op_q <= fbcmc_pkg::OP_READ;
      flash_o <= {1'b1, 1'b1, 1'b1, 1'b0, 21'h000000, 16'h0000};
    end else begin
      state <= next_state;
      step <= next_step;
      flash_o <= next_pins;
      if (next_state == fbcmc_pkg::ST_SETUP) begin
        cur <= rom_step;
      end
      if (launch) begin
        op_q <= launch_op;
      end
    end
  end

  // ****************************************************************
  // Mode mirror and flags.
  // ****************************************************************

  // The mirror starts in read mode for every bank, as the flash does after power-up.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      modes <= fbcmc_pkg::MODES_RESET;
      secured <= 1'b0;
    end else if (finish) begin
      case (op_q)
        fbcmc_pkg::OP_RESET: modes <= fbcmc_pkg::MODES_RESET;
        fbcmc_pkg::OP_AUTOSEL: modes[2*bank_sel +: 2] <= fbcmc_pkg::BM_AUTOSEL;
        fbcmc_pkg::OP_QUERY: modes <= {fbcmc_pkg::BANKS{fbcmc_pkg::BM_QUERY}};
        fbcmc_pkg::OP_SEC_ENTER: secured <= 1'b1;
        fbcmc_pkg::OP_SEC_EXIT: secured <= 1'b0;
        default: secured <= secured;
      endcase
    end
  end

  // A timeout seen on a poll arms one reset; the hit wins over a clear in the same cycle.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      timeout_flag <= 1'b0;
      pending_reset <= 1'b0;
      refused <= 1'b0;
    end else begin
      timeout_flag <= timeout_hit || (timeout_flag && !clr_timeout);
      pending_reset <= timeout_hit || (pending_reset && !launch);
      if (ctrl_wr) begin
        refused <= ctrl_refuse;
      end
    end
  end

  // ****************************************************************
  // Software registers.
  // ****************************************************************
  assign status_word = {16'h0000, modes, 4'h0, secured, refused, timeout_flag, busy};
  assign next_rdata =
    (sw_addr_i == fbcmc_pkg::REG_CTRL) ? {28'h0000000, poll_q, op_q} :
    (sw_addr_i == fbcmc_pkg::REG_ADDR) ? {11'h000, addr_q} :
    (sw_addr_i == fbcmc_pkg::REG_WDATA) ? {16'h0000, wdata_q} :
    (sw_addr_i == fbcmc_pkg::REG_STATUS) ? status_word :
    (sw_addr_i == fbcmc_pkg::REG_RDATA) ? {16'h0000, rdata_q} : 32'h00000000;

  // Address and data stay frozen while a sequence runs, since the table reads them live.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_q <= 21'h000000;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      poll_q <= 1'b0;
      sw_rdata_o <= 32'h00000000;
    end else begin
      if (sw_wr_i && !busy && (sw_addr_i == fbcmc_pkg::REG_ADDR)) begin
        addr_q <= sw_wdata_i[20:0];
      end
      if (sw_wr_i && !busy && (sw_addr_i == fbcmc_pkg::REG_WDATA)) begin
        wdata_q <= sw_wdata_i[15:0];
      end
      if (ctrl_go) begin
        poll_q <= sw_wdata_i[fbcmc_pkg::CTRL_POLL_BIT];
      end
      if (sample) begin
        rdata_q <= flash_dq_i;
      end
      sw_rdata_o <= sw_rd_i ? next_rdata : 32'h00000000;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  write_strobe_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !flash_o.we_n |-> (flash_o.oe_n && !flash_o.ce_n))
    else $error("write strobe low without select or with output strobe");
  data_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(flash_o.we_n) |-> (flash_o.dq_oe && !flash_o.ce_n && $stable(flash_o.dq)))
    else $error("data not held across write strobe rise");
  addr_setup_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(flash_o.we_n) |-> ($stable(flash_o.addr) && $past(!flash_o.ce_n)))
    else $error("address not set up before write strobe fall");
  reset_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (finish && (op_q == fbcmc_pkg::OP_RESET)) |=> (modes == fbcmc_pkg::MODES_RESET))
    else $error("reset did not return banks to read mode");
  autosel_entry_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (finish && (op_q == fbcmc_pkg::OP_AUTOSEL)) |=>
    (sel_mode == fbcmc_pkg::BM_AUTOSEL) && $past(flash_o.dq == fbcmc_pkg::CMD_AUTOSEL, 3))
    else $error("autoselect entry did not mark bank");
  autosel_refuse_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (ctrl_wr && !busy && (ctrl_op == fbcmc_pkg::OP_AUTOSEL) && (sel_mode != fbcmc_pkg::BM_READ))
    |=> (refused && (state == fbcmc_pkg::ST_IDLE)))
    else $error("autoselect launched outside read mode");
  query_cycle_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ($fell(flash_o.we_n) && (op_q == fbcmc_pkg::OP_QUERY)) |->
    ((flash_o.addr == fbcmc_pkg::QUERY_ADDR) && (flash_o.dq == fbcmc_pkg::CMD_QUERY)))
    else $error("query command on wrong address or data");
  timeout_reset_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    timeout_hit |-> ##[1:RESET_LAT] (!flash_o.we_n && (flash_o.dq == fbcmc_pkg::CMD_RESET)))
    else $error("no reset written after timeout flag");
  secured_exit_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (finish && (op_q == fbcmc_pkg::OP_SEC_EXIT)) |=> !secured ##1 !secured)
    else $error("secured region not left after exit sequence");

endmodule

//--- verilog/fbcmc_pkg.sv
package fbcmc_pkg;

  // ****************************************************************
  // Clock and pin timing.
  // ****************************************************************
  localparam int CLK_NS = 50;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************************************
  // Flash bus shape and command words.
  // ****************************************************************
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BANKS = 4;
  localparam int BANK_LSB = 19;
  localparam int TIMEOUT_BIT = 5;
  localparam logic [20:0] UNLOCK1_ADDR = 21'h000555;
  localparam logic [20:0] UNLOCK2_ADDR = 21'h0002AA;
  localparam logic [20:0] QUERY_ADDR = 21'h000055;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
  localparam logic [15:0] CMD_SEC_ENTER = 16'h0088;
  localparam logic [15:0] CMD_SEC_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_SEC_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_QUERY = 16'h0098;

  // ****************************************************************
  // Query table of the device, word addresses and fixed contents.
  // ****************************************************************
  localparam logic [20:0] Q_BANK_SECTOR_COUNT_SUMMARY = 21'h00004A;
  localparam logic [20:0] Q_BURST_MODE_SUPPORT = 21'h00004B;
  localparam logic [20:0] Q_PAGE_MODE_SUPPORT = 21'h00004C;
  localparam logic [20:0] Q_ACCEL_SUPPLY_MIN = 21'h00004D;
  localparam logic [20:0] Q_ACCEL_SUPPLY_MAX = 21'h00004E;
  localparam logic [20:0] Q_BOOT_LOCATION_FLAG = 21'h00004F;
  localparam logic [20:0] Q_PROGRAM_SUSPEND_SUPPORT = 21'h000050;
  localparam logic [20:0] Q_BANK_ORGANIZATION = 21'h000057;
  localparam logic [20:0] Q_BANK1_SECTOR_COUNT = 21'h000058;
  localparam logic [20:0] Q_BANK2_SECTOR_COUNT = 21'h000059;
  localparam logic [20:0] Q_BANK3_SECTOR_COUNT = 21'h00005A;
  localparam logic [20:0] Q_BANK4_SECTOR_COUNT = 21'h00005B;
  localparam logic [15:0] QV_BURST_NONE = 16'h0000;
  localparam logic [15:0] QV_PAGE_NONE = 16'h0000;
  localparam logic [15:0] QV_PAGE_FOUR = 16'h0001;
  localparam logic [15:0] QV_PAGE_EIGHT = 16'h0002;
  localparam logic [15:0] QV_ACCEL_MIN = 16'h0085;
  localparam logic [15:0] QV_ACCEL_MAX = 16'h0095;
  localparam logic [15:0] QV_BOOT_BOTTOM = 16'h0002;
  localparam logic [15:0] QV_BOOT_TOP = 16'h0003;
  localparam logic [15:0] QV_PROG_SUSPEND = 16'h0001;

  // ****************************************************************
  // Software register map and fields.
  // ****************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_POLL_BIT = 3;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_TIMEOUT_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_SECURED_BIT = 3;
  localparam int ST_MODES_LSB = 8;
  localparam logic [7:0] MODES_RESET = 8'h00;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RESET = 3'h2,
    OP_AUTOSEL = 3'h3,
    OP_SEC_ENTER = 3'h4,
    OP_SEC_EXIT = 3'h5,
    OP_QUERY = 3'h6
  } fbcmc_op_e;

  typedef enum logic [1:0] {
    BM_READ = 2'h0,
    BM_AUTOSEL = 2'h1,
    BM_QUERY = 2'h2
  } fbcmc_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_STROBE = 5'h04,
    ST_HOLD = 5'h08,
    ST_GAP = 5'h10
  } fbcmc_state_e;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic [20:0] addr;
    logic [15:0] dq;
  } fbcmc_pins_s;

  typedef struct packed {
    logic last;
    logic rd;
    logic [20:0] addr;
    logic [15:0] data;
  } fbcmc_step_s;

endpackage

//--- verilog/fbcmc_pulse_timer.sv
module fbcmc_pulse_timer #(
  parameter int W = 4
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  output logic done_o
);

  logic [W-1:0] cnt;

  // The count is loaded one less than the pulse length so that the strobe lasts exactly N cycles.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= '0;
    end else if (load_i) begin
      cnt <= load_val_i - W'(1);
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

  assign done_o = (cnt == '0);

endmodule

//--- verilog/fbcmc_seq_rom.sv
module fbcmc_seq_rom (
  input wire fbcmc_pkg::fbcmc_op_e op_i,
  input wire logic [1:0] step_i,
  input wire logic [20:0] user_addr_i,
  input wire logic [15:0] user_data_i,
  output fbcmc_pkg::fbcmc_step_s step_o
);

  logic [20:0] bank_cmd_addr;
  fbcmc_pkg::fbcmc_step_s unlock1;
  fbcmc_pkg::fbcmc_step_s unlock2;

  // The command cycle of the autoselect sequence carries the bank field of the user address.
  assign bank_cmd_addr = {user_addr_i[20:fbcmc_pkg::BANK_LSB],
                          fbcmc_pkg::UNLOCK1_ADDR[fbcmc_pkg::BANK_LSB-1:0]};
  assign unlock1 = {1'b0, 1'b0, fbcmc_pkg::UNLOCK1_ADDR, fbcmc_pkg::CMD_UNLOCK1};
  assign unlock2 = {1'b0, 1'b0, fbcmc_pkg::UNLOCK2_ADDR, fbcmc_pkg::CMD_UNLOCK2};

  // One bus cycle per step; the last flag ends the sequence.
  always_comb begin
    step_o = {1'b1, 1'b1, user_addr_i, user_data_i};
    case (op_i)
      fbcmc_pkg::OP_READ: step_o = {1'b1, 1'b1, user_addr_i, user_data_i};
      fbcmc_pkg::OP_WRITE: step_o = {1'b1, 1'b0, user_addr_i, user_data_i};
      fbcmc_pkg::OP_RESET: step_o = {1'b1, 1'b0, user_addr_i, fbcmc_pkg::CMD_RESET};
      fbcmc_pkg::OP_QUERY: begin
        step_o = {1'b1, 1'b0, fbcmc_pkg::QUERY_ADDR, fbcmc_pkg::CMD_QUERY};
      end
      fbcmc_pkg::OP_AUTOSEL: begin
        case (step_i)
          2'h0: step_o = unlock1;
          2'h1: step_o = unlock2;
          default: step_o = {1'b1, 1'b0, bank_cmd_addr, fbcmc_pkg::CMD_AUTOSEL};
        endcase
      end
      fbcmc_pkg::OP_SEC_ENTER: begin
        case (step_i)
          2'h0: step_o = unlock1;
          2'h1: step_o = unlock2;
          default: step_o = {1'b1, 1'b0, fbcmc_pkg::UNLOCK1_ADDR, fbcmc_pkg::CMD_SEC_ENTER};
        endcase
      end
      fbcmc_pkg::OP_SEC_EXIT: begin
        case (step_i)
          2'h0: step_o = unlock1;
          2'h1: step_o = unlock2;
          2'h2: step_o = {1'b0, 1'b0, fbcmc_pkg::UNLOCK1_ADDR, fbcmc_pkg::CMD_SEC_EXIT1};
          default: step_o = {1'b1, 1'b0, user_addr_i, fbcmc_pkg::CMD_SEC_EXIT2};
        endcase
      end
      default: step_o = {1'b1, 1'b1, user_addr_i, user_data_i};
    endcase
  end

endmodule
